// *** rtl/shd_pkg.sv ***
// ****************************************************************
// Overview of operation
// - Request/clear mode runs half duplex, never sending and receiving together.
// - Terminal raises request-to-send when it has data for the device.
// - Synchronous channel in request/clear mode grants clear-to-send only with block length free.
// - Message channel in request/clear mode grants clear-to-send only with 32 characters free.
// - In request/clear mode, no data goes toward the terminal while its request-to-send stands.
// - In request/clear mode, clear-to-send rests low, raised only to answer request-to-send.
// - In request/clear mode, clear-to-send drops once the terminal drops request-to-send.
// - Inbound frame header is decoded for size and checked against space.
// - Clear-to-send drops whenever space is short for a frame, or for a block in request/clear mode.
// - Message channel holds clear-to-send low until aggregate link is up.
// - Data-set-ready is held high.
// - Carrier detect is high only while the device sends to the terminal in request/clear mode, and held high with no flow control.
// - Ring indicator is held low.
// - Message channel: request/clear selects half duplex, none full duplex.
// - Synchronous channel with no flow control holds clear-to-send high.
// ****************************************************************
package shd_pkg;

   // ****************************************************************
   // Sizes and thresholds
   // ****************************************************************
   localparam int                  SHD_DW           = 8;   // Character width
   localparam int                  SHD_CW           = 16;  // Character count width
   localparam logic [SHD_CW-1:0]   SHD_MSG_MIN_FREE = 16'h0020; // 32 characters
   localparam int                  SHD_FIFO_DEPTH   = 2;
   // Header bytes carrying the frame length (low byte, then six high bits)
   localparam logic [1:0]          SHD_HDR_IDX_LO   = 2'h1;
   localparam logic [1:0]          SHD_HDR_IDX_HI   = 2'h2;
   localparam int                  SHD_HDR_HI_BITS  = 6;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic              msg_chan;    // 1: message protocol, 0: synchronous
      logic              flow_reqclr; // 1: request/clear, 0: none
      logic              link_up;     // Aggregate link established
      logic [SHD_CW-1:0] block_len;   // Configured block length
   } shd_cfg_t;

   typedef struct packed {
      logic cts;
      logic dsr;
      logic carrier_detect_out;
      logic ri;
   } shd_modem_t;

   typedef enum logic [1:0] {
      SHD_IDLE,
      SHD_GRANT,
      SHD_SEND
   } shd_state_t;

endpackage : shd_pkg

// *** rtl/shd_flow_ctl.sv ***
`timescale 1ns/1ps
module shd_flow_ctl #(
   parameter int DW = shd_pkg::SHD_DW,
   parameter int CW = shd_pkg::SHD_CW
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   // Channel configuration and buffer state
   input  wire shd_pkg::shd_cfg_t    cfg,
   input  wire logic [CW-1:0]        free_space,
   // Modem lines from and to the terminal
   input  wire logic                 rts,
   output logic                      cts,
   output logic                      dsr,
   output logic                      carrier_detect_out,
   output logic                      ri,
   // Outbound words from the multiplexer
   input  wire logic                 src_valid,
   input  wire logic [DW-1:0]        src_data,
   output logic                      src_ready,
   // Outbound words to the terminal
   output logic                      tx_valid,
   output logic [DW-1:0]             tx_data,
   input  wire logic                 tx_ready,
   // Inbound words from the terminal
   input  wire logic                 rx_valid,
   input  wire logic [DW-1:0]        rx_data,
   input  wire logic                 rx_last,
   // Inbound words to the multiplexer
   output logic                      rcv_valid,
   output logic [DW-1:0]             rcv_data,
   output logic                      rcv_last
);
   import shd_pkg::*;

   // ****************************************************************
   // State record
   // ****************************************************************
   typedef struct packed {
      shd_state_t                  state;
      shd_modem_t                  modem;
      logic [SHD_FIFO_DEPTH-1:0][DW-1:0] mem;
      logic                        wp;
      logic                        rp;
      logic [1:0]                  cnt;
      logic                        src_ready;
      logic                        tx_valid;
      logic [DW-1:0]               tx_data;
      logic                        rcv_valid;
      logic [DW-1:0]               rcv_data;
      logic                        rcv_last;
      logic [1:0]                  hdr_idx;
      logic [DW-1:0]               hdr_lo;
      logic [CW-1:0]               need;
      logic                        short;
   } shd_reg_t;

   shd_reg_t st_r;
   shd_reg_t st_nxt;

   logic     push;
   logic     pop;
   logic     rx_take;
   logic     space_ok;
   logic     send_ok;
   logic [1:0] cnt_pop;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      st_nxt  = st_r;
      push    = src_valid && st_r.src_ready;
      pop     = st_r.tx_valid && tx_ready;
      // Inbound words only count while the line is granted
      rx_take = rx_valid && st_r.modem.cts;
      cnt_pop = st_r.cnt - {1'b0, pop};

      // Two-entry outbound buffer
      if (push) begin
         st_nxt.mem[st_r.wp] = src_data;
         st_nxt.wp           = ~st_r.wp;
      end
      if (pop) begin
         st_nxt.rp = ~st_r.rp;
      end
      st_nxt.cnt       = cnt_pop + {1'b0, push};
      // Ready is registered; it only promises room the next cycle holds
      st_nxt.src_ready = (st_nxt.cnt != 2'(SHD_FIFO_DEPTH));

      // Header decode of message frames
      if (rx_take) begin
         if (rx_last) begin
            st_nxt.hdr_idx = 2'h0;
         end else if (st_r.hdr_idx != 2'h3) begin
            st_nxt.hdr_idx = st_r.hdr_idx + 2'h1;
         end
         if (st_r.hdr_idx == SHD_HDR_IDX_LO) begin
            st_nxt.hdr_lo = rx_data;
         end
      end
      // Shortage clears at frame end or once space has freed up
      if ((rx_take && rx_last) || (free_space >= st_r.need)) begin
         st_nxt.short = 1'b0;
      end
      // Set wins over clear in the same cycle
      if (cfg.msg_chan && rx_take && (st_r.hdr_idx == SHD_HDR_IDX_HI)) begin
         st_nxt.need = CW'({rx_data[SHD_HDR_HI_BITS-1:0], st_r.hdr_lo});
         if (CW'({rx_data[SHD_HDR_HI_BITS-1:0], st_r.hdr_lo}) > free_space) begin
            st_nxt.short = 1'b1;
         end
      end

      // Space test for a new grant
      if (cfg.msg_chan) begin
         space_ok = (free_space >= SHD_MSG_MIN_FREE) && cfg.link_up && !st_nxt.short;
      end else begin
         space_ok = (free_space >= cfg.block_len);
      end

      // Line ownership in request/clear mode
      if (cfg.flow_reqclr) begin
         case (st_r.state)
            SHD_IDLE: begin
               if (rts && space_ok) begin
                  st_nxt.state = SHD_GRANT;
               end else if (!rts && (cnt_pop != 2'h0 || push)) begin
                  st_nxt.state = SHD_SEND;
               end
            end
            SHD_GRANT: begin
               if (!rts || !space_ok) begin
                  st_nxt.state = SHD_IDLE;
               end
            end
            SHD_SEND: begin
               // Terminal request takes the line back at once
               if (rts) begin
                  st_nxt.state = SHD_IDLE;
               end else if (st_nxt.cnt == 2'h0) begin
                  st_nxt.state = SHD_IDLE;
               end
            end
            default: begin
               st_nxt.state = SHD_IDLE;
            end
         endcase
         send_ok = (st_nxt.state == SHD_SEND) && !rts;
      end else begin
         st_nxt.state = SHD_IDLE;
         send_ok      = 1'b1;
      end

      // Head of buffer presented to the terminal
      st_nxt.tx_valid = send_ok && (st_nxt.cnt != 2'h0);
      if (push && cnt_pop == 2'h0) begin
         st_nxt.tx_data = src_data;
      end else begin
         st_nxt.tx_data = st_r.mem[st_nxt.rp];
      end

      // Modem outputs
      st_nxt.modem.dsr = 1'b1;
      st_nxt.modem.ri  = 1'b0;
      if (cfg.flow_reqclr) begin
         st_nxt.modem.cts                = (st_nxt.state == SHD_GRANT);
         st_nxt.modem.carrier_detect_out = st_nxt.tx_valid;
      end else if (cfg.msg_chan) begin
         // Full duplex still guards against frames with no room
         st_nxt.modem.cts                = cfg.link_up && !st_nxt.short;
         st_nxt.modem.carrier_detect_out = 1'b1;
      end else begin
         st_nxt.modem.cts                = 1'b1;
         st_nxt.modem.carrier_detect_out = 1'b1;
      end

      // Inbound words forwarded one cycle later
      st_nxt.rcv_valid = rx_take;
      st_nxt.rcv_data  = rx_take ? rx_data : st_r.rcv_data;
      st_nxt.rcv_last  = rx_take && rx_last;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state record
   assign cts                = st_r.modem.cts;
   assign dsr                = st_r.modem.dsr;
   assign carrier_detect_out = st_r.modem.carrier_detect_out;
   assign ri                 = st_r.modem.ri;
   assign src_ready          = st_r.src_ready;
   assign tx_valid           = st_r.tx_valid;
   assign tx_data            = st_r.tx_data;
   assign rcv_valid          = st_r.rcv_valid;
   assign rcv_data           = st_r.rcv_data;
   assign rcv_last           = st_r.rcv_last;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_half_duplex;
      @(posedge mclk) disable iff (sys_rst)
      cfg.flow_reqclr |=> !(cts && tx_valid);
   endproperty
   a_half_duplex: assert property (p_half_duplex)
      else $error("grant and transmit overlap");

   property p_rts_stops_tx;
      @(posedge mclk) disable iff (sys_rst)
      (cfg.flow_reqclr && rts) |=> !tx_valid;
   endproperty
   a_rts_stops_tx: assert property (p_rts_stops_tx)
      else $error("word offered while request stands");

   property p_cts_answers_rts;
      @(posedge mclk) disable iff (sys_rst)
      (cfg.flow_reqclr && $rose(cts)) |-> $past(rts);
   endproperty
   a_cts_answers_rts: assert property (p_cts_answers_rts)
      else $error("clear raised without request");

   property p_cts_drops;
      @(posedge mclk) disable iff (sys_rst)
      (cfg.flow_reqclr && !rts) |=> !cts;
   endproperty
   a_cts_drops: assert property (p_cts_drops)
      else $error("clear held after request dropped");

   property p_sync_space;
      @(posedge mclk) disable iff (sys_rst)
      (cfg.flow_reqclr && !cfg.msg_chan && free_space < cfg.block_len) |=> !cts;
   endproperty
   a_sync_space: assert property (p_sync_space)
      else $error("clear with less than a block free");

   property p_msg_space;
      @(posedge mclk) disable iff (sys_rst)
      (cfg.flow_reqclr && cfg.msg_chan && free_space < SHD_MSG_MIN_FREE) |=> !cts;
   endproperty
   a_msg_space: assert property (p_msg_space)
      else $error("clear with under 32 free");

   property p_link_first;
      @(posedge mclk) disable iff (sys_rst)
      (cfg.msg_chan && !cfg.link_up) |=> !cts;
   endproperty
   a_link_first: assert property (p_link_first)
      else $error("clear before aggregate link");

   property p_frame_short;
      @(posedge mclk) disable iff (sys_rst)
      (cfg.msg_chan && rx_valid && cts && !rx_last && st_r.hdr_idx == SHD_HDR_IDX_HI
       && CW'({rx_data[SHD_HDR_HI_BITS-1:0], st_r.hdr_lo}) > free_space) |=> !cts;
   endproperty
   a_frame_short: assert property (p_frame_short)
      else $error("clear kept for oversize frame");

   property p_carrier;
      @(posedge mclk) disable iff (sys_rst)
      cfg.flow_reqclr |=> (carrier_detect_out == tx_valid);
   endproperty
   a_carrier: assert property (p_carrier)
      else $error("carrier not tied to transmit");

   property p_fixed_lines;
      @(posedge mclk) disable iff (sys_rst)
      1'b1 |=> (dsr && !ri);
   endproperty
   a_fixed_lines: assert property (p_fixed_lines)
      else $error("fixed modem line wrong");

   property p_sync_none;
      @(posedge mclk) disable iff (sys_rst)
      (!cfg.flow_reqclr && !cfg.msg_chan) |=> cts;
   endproperty
   a_sync_none: assert property (p_sync_none)
      else $error("clear low with no flow control");

   property p_msg_full;
      @(posedge mclk) disable iff (sys_rst)
      (!cfg.flow_reqclr && cfg.msg_chan && cfg.link_up && !st_nxt.short) |=> cts;
   endproperty
   a_msg_full: assert property (p_msg_full)
      else $error("full duplex clear missing");

endmodule : shd_flow_ctl

// *** tb/shd_term_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Terminal model: half-duplex synchronous terminal
// ****************************************************************
module shd_term_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Lines from the device
   input  wire logic       cts,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   // Lines toward the device
   output logic            rts,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_last,
   output logic            tx_ready
);
   import shd_pkg::*;
   logic       stall = 1'b0;
   logic [7:0] got_q[$];
   initial begin
      rts = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
   end
   assign tx_ready = !stall;
   // Words handed over by the device
   always @(posedge mclk) begin
      if (!sys_rst && tx_valid && tx_ready) begin
         got_q.push_back(tx_data);
      end
   end
   // Ask for the line
   task automatic req_line();
      @(negedge mclk);
      rts = 1'b1;
   endtask : req_line
   // Send n words while granted; gives up if the grant stays away
   task automatic send_words(input int n, input logic [15:0] len, output int sent);
      int waited;
      sent = 0;
      waited = 0;
      while (sent < n && waited < 20) begin
         @(negedge mclk);
         if (cts) begin
            rx_valid = 1'b1;
            rx_data = (sent == 1) ? len[7:0] : (sent == 2) ? {2'h0, len[13:8]} : 8'hA0 + 8'(sent);
            rx_last = (sent == n - 1);
            sent++;
         end else begin
            // Idle data line must not keep its last value
            rx_valid = 1'b0;
            rx_last = 1'b0;
            rx_data = ~rx_data;
            waited++;
         end
      end
      @(negedge mclk);
      rx_valid = 1'b0;
      rx_last = 1'b0;
      rx_data = ~rx_data;
      rts = 1'b0;
   endtask : send_words
endmodule : shd_term_model

// *** tb/sync_half_duplex_flow_ctl_tb.sv ***
`timescale 1ns/1ps
module sync_half_duplex_flow_ctl_tb;
   import shd_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, mon_on = 1'b0;
   shd_cfg_t cfg = '{1'b0, 1'b1, 1'b0, 16'h0010};
   logic [15:0] free_space = 16'h0010;
   logic rts, cts, dsr, carrier_detect_out, ri, src_valid = 1'b0, src_ready;
   logic [7:0] src_data = 8'h00, tx_data, rx_data, rcv_data;
   logic tx_valid, tx_ready, rx_valid, rx_last, rcv_valid, rcv_last;
   int error_cnt = 0, n_compared = 0, rcv_cnt = 0;
   logic [7:0] rcv_byte = 8'h00;
   logic rcv_end = 1'b0;
   // ****************************************************************
   // Clock, device and terminal
   // ****************************************************************
   always #25 mclk = ~mclk;
   shd_flow_ctl dut (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .free_space(free_space),
      .rts(rts), .cts(cts), .dsr(dsr), .carrier_detect_out(carrier_detect_out), .ri(ri),
      .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rcv_valid(rcv_valid), .rcv_data(rcv_data), .rcv_last(rcv_last));
   shd_term_model term (.mclk(mclk), .sys_rst(sys_rst), .cts(cts), .tx_valid(tx_valid),
      .tx_data(tx_data), .rts(rts), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .tx_ready(tx_ready));
   // Inbound pulses stand one cycle; taken mid-cycle where they are settled
   always @(negedge mclk) begin
      if (rcv_valid) begin
         rcv_cnt++;
         rcv_byte = rcv_data;
         rcv_end = rcv_last;
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // Static lines and carrier, watched all through request/clear mode
   always @(negedge mclk) begin
      if (mon_on) begin
         check("dsr", dsr, 1'b1);
         check("ri", ri, 1'b0);
         check("carrier", carrier_detect_out, tx_valid);
         check("duplex", cts & tx_valid, 1'b0);
      end
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_sync_grant();
      int sent, base;
      check("cts rest", cts, 1'b0);
      free_space = 16'h000F;
      term.req_line();
      repeat (4) @(negedge mclk);
      check("cts short", cts, 1'b0);
      free_space = 16'h0010;
      @(negedge mclk);
      check("cts grant", cts, 1'b1);
      free_space = 16'h000F;
      @(negedge mclk);
      check("cts drop", cts, 1'b0);
      free_space = 16'h0010;
      base = rcv_cnt;
      term.send_words(4, 16'h0004, sent);
      repeat (2) @(negedge mclk);
      check("cts release", cts, 1'b0);
      check("rcv words", 16'(rcv_cnt - base), 16'h0004);
      check("rcv last data", rcv_byte, 8'hA3);
      check("rcv last flag", rcv_end, 1'b1);
   endtask : t_sync_grant
   // Outbound words held off by the terminal's request, then re-offered
   task automatic t_outbound();
      int acc, sent;
      acc = 0;
      term.stall = 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(negedge mclk);
         // Word stands until a high ready carries it over the next edge
         src_valid = 1'b1;
         src_data = 8'h50 + 8'(acc);
         if (src_ready) acc++;
      end
      @(negedge mclk);
      src_valid = 1'b0;
      check("buffer fill", 16'(acc), 16'(SHD_FIFO_DEPTH));
      check("offered", tx_valid, 1'b1);
      term.req_line();
      repeat (3) @(negedge mclk);
      check("withdrawn", tx_valid, 1'b0);
      check("granted", cts, 1'b1);
      term.send_words(2, 16'h0002, sent);
      term.stall = 1'b0;
      repeat (8) @(negedge mclk);
      check("drained", 16'(term.got_q.size()), 16'(SHD_FIFO_DEPTH));
      for (int i = 0; i < term.got_q.size(); i++) begin
         check("order", term.got_q[i], 8'h50 + 8'(i));
      end
      term.got_q.delete();
   endtask : t_outbound
   task automatic t_msg();
      int sent;
      cfg.msg_chan = 1'b1;
      cfg.link_up = 1'b0;
      free_space = 16'h0100;
      term.req_line();
      repeat (4) @(negedge mclk);
      check("cts no link", cts, 1'b0);
      free_space = 16'h001F;
      cfg.link_up = 1'b1;
      repeat (3) @(negedge mclk);
      check("cts below 32", cts, 1'b0);
      free_space = SHD_MSG_MIN_FREE;
      @(negedge mclk);
      check("cts at 32", cts, 1'b1);
      free_space = 16'h0100;
      term.send_words(8, 16'h0008, sent);
      check("fit frame", 16'(sent), 16'h0008);
      term.req_line();
      term.send_words(8, 16'h0200, sent);
      check("long frame", 16'(sent < 6), 16'h0001);
      free_space = 16'h0300;
      repeat (3) @(negedge mclk);
   endtask : t_msg
   task automatic t_none();
      int sent;
      mon_on = 1'b0;
      cfg = '{1'b0, 1'b0, 1'b0, 16'h0010};
      free_space = 16'h0000;
      repeat (2) @(negedge mclk);
      check("cts sync none", cts, 1'b1);
      check("carrier none", carrier_detect_out, 1'b1);
      cfg = '{1'b1, 1'b0, 1'b1, 16'h0010};
      free_space = 16'h0010;
      term.req_line();
      src_valid = 1'b1;
      src_data = 8'h77;
      @(negedge mclk);
      src_valid = 1'b0;
      repeat (3) @(negedge mclk);
      check("cts msg none", cts, 1'b1);
      check("full duplex", 16'(term.got_q.size()), 16'h0001);
      term.send_words(1, 16'h0001, sent);
      cfg.link_up = 1'b0;
      repeat (2) @(negedge mclk);
      check("cts none no link", cts, 1'b0);
   endtask : t_none
   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (2) @(negedge mclk);
      mon_on = 1'b1;
      t_sync_grant();
      t_outbound();
      t_msg();
      t_none();
      report_and_stop();
   end
   // Whole run needs some 100 cycles; allow thirty times that
   initial begin
      #150000;
      error_cnt++;
      report_and_stop();
   end
endmodule : sync_half_duplex_flow_ctl_tb
